// ### src/gpr_pkg.sv
// Package of offsets, field layouts and types for the parameter registers
package gpr_pkg;

  // ==========================================================================
  // Register byte offsets within the register space
  localparam logic [15:0] GPR_OFF_DEST     = 16'h8100;
  localparam logic [15:0] GPR_OFF_SIZE     = 16'h8104;
  localparam logic [15:0] GPR_OFF_SRC      = 16'h8108;
  localparam logic [15:0] GPR_OFF_SRC_COL  = 16'h810c;
  localparam logic [15:0] GPR_OFF_PAT_LO   = 16'h8110;
  localparam logic [15:0] GPR_OFF_PAT_HI   = 16'h8114;
  localparam logic [15:0] GPR_OFF_PAT_W0   = 16'h8120;
  localparam logic [15:0] GPR_OFF_PAT_W1   = 16'h8124;
  localparam logic [15:0] GPR_OFF_PAT_W2   = 16'h8128;
  localparam logic [15:0] GPR_OFF_PAT_W3   = 16'h812c;
  localparam logic [15:0] GPR_OFF_LEG_WR   = 16'h8140;
  localparam logic [15:0] GPR_OFF_LEG_RD   = 16'h8144;
  localparam logic [15:0] GPR_OFF_LINE_TRG = 16'h8204;
  localparam logic [15:0] GPR_OFF_BLIT_TRG = 16'h8208;

  // ==========================================================================
  // Field layout and reset values
  localparam int          GPR_HI_MSB     = 31;
  localparam int          GPR_HI_LSB     = 16;
  localparam int          GPR_LO_MSB     = 15;
  localparam int          GPR_VLEN_BITS  = 14;
  localparam logic [31:0] GPR_RESET_WORD = 32'h0000_0000;
  localparam int          GPR_PAT_WORDS  = 4;

  // ==========================================================================
  // Register bus request and answer
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } gpr_req_t;

  typedef struct packed {
    logic        rvalid;
    logic        hit;
    logic [31:0] rdata;
  } gpr_rsp_t;

  // Operand bundle handed to the rendering engine with each start
  typedef struct packed {
    logic        is_line;
    logic        empty;
    logic [15:0] dest_y;
    logic [15:0] dest_x;
    logic [15:0] width_or_len;
    logic [15:0] height_or_err;
    logic [15:0] src_x_or_axial;
    logic [15:0] src_y_or_diag;
    logic [15:0] source_color_zero;
    logic [15:0] source_color_one;
    logic [15:0] pattern_color_zero;
    logic [15:0] pattern_color_one;
    logic [15:0] pattern_color_two;
    logic [15:0] pattern_color_three;
    logic [127:0] pattern;
  } gpr_op_t;

  typedef enum logic [2:0] {
    GPR_IDLE  = 3'b001,
    GPR_BLIT  = 3'b010,
    GPR_LINE  = 3'b100
  } gpr_state_t;

endpackage

// ### src/gpr_param_regs.sv
// Parameter register bank of the 2D rendering pipeline
`timescale 1ns/1ps

module gpr_param_regs
  import gpr_pkg::*;
(
  input  wire logic     clock_in,
  input  wire logic     resetn_in,
  input  wire gpr_req_t req_in,
  input  wire logic     engine_busy_in,
  output gpr_rsp_t      rsp_out,
  output gpr_op_t       op_out,
  output logic          start_out,
  output logic [31:0]   legacy_write_ctl_out,
  output logic [31:0]   legacy_read_ctl_out,
  output logic          busy_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    gpr_state_t  state;
    logic [31:0] dest;
    logic [31:0] size;
    logic [31:0] src;
    logic [31:0] src_col;
    logic [31:0] pat_lo;
    logic [31:0] pat_hi;
    logic [GPR_PAT_WORDS-1:0][31:0] pat;
    logic [31:0] leg_wr;
    logic [31:0] leg_rd;
    logic [31:0] line_trg;
    logic [31:0] blit_trg;
    gpr_rsp_t    rsp;
    gpr_op_t     op;
    logic        start;
    logic        busy;
  } gpr_regs_t;

  gpr_regs_t s_reg;
  gpr_regs_t s_next;

  function automatic logic [15:0] hi_half(input logic [31:0] w);
    hi_half = w[GPR_HI_MSB:GPR_HI_LSB];
  endfunction

  function automatic logic [15:0] lo_half(input logic [31:0] w);
    lo_half = w[GPR_LO_MSB:0];
  endfunction

  // Snapshot of operands; line mode also cuts the length to 14 bits and clears empty
  function automatic gpr_op_t build_op(input gpr_regs_t r,
                                       input logic line);
    gpr_op_t o;
    o = '0;
    o.is_line             = line;
    o.dest_y              = hi_half(r.dest);
    o.dest_x              = lo_half(r.dest);
    if (line) begin
      o.width_or_len = {{(16-GPR_VLEN_BITS){1'b0}},
                        r.size[GPR_HI_LSB+GPR_VLEN_BITS-1:GPR_HI_LSB]};
      o.empty        = 1'b0;
    end else begin
      o.width_or_len = hi_half(r.size);
      o.empty        = (hi_half(r.size) == 16'h0000) ||
                       (lo_half(r.size) == 16'h0000);
    end
    o.height_or_err       = lo_half(r.size);
    o.src_x_or_axial      = hi_half(r.src);
    o.src_y_or_diag       = lo_half(r.src);
    o.source_color_zero   = hi_half(r.src_col);
    o.source_color_one    = lo_half(r.src_col);
    o.pattern_color_zero  = hi_half(r.pat_lo);
    o.pattern_color_one   = lo_half(r.pat_lo);
    o.pattern_color_two   = hi_half(r.pat_hi);
    o.pattern_color_three = lo_half(r.pat_hi);
    o.pattern             = {r.pat[3], r.pat[2], r.pat[1], r.pat[0]};
    build_op = o;
  endfunction

  // ==========================================================================
  // Decode, storage and trigger
  always_comb begin
    s_next            = s_reg;
    s_next.start      = 1'b0;
    s_next.rsp.rvalid = req_in.rd;
    s_next.rsp.hit    = 1'b1;
    unique case (req_in.addr)
      GPR_OFF_DEST:     s_next.rsp.rdata = s_reg.dest;
      GPR_OFF_SIZE:     s_next.rsp.rdata = s_reg.size;
      GPR_OFF_SRC:      s_next.rsp.rdata = s_reg.src;
      GPR_OFF_SRC_COL:  s_next.rsp.rdata = s_reg.src_col;
      GPR_OFF_PAT_LO:   s_next.rsp.rdata = s_reg.pat_lo;
      GPR_OFF_PAT_HI:   s_next.rsp.rdata = s_reg.pat_hi;
      GPR_OFF_PAT_W0:   s_next.rsp.rdata = s_reg.pat[0];
      GPR_OFF_PAT_W1:   s_next.rsp.rdata = s_reg.pat[1];
      GPR_OFF_PAT_W2:   s_next.rsp.rdata = s_reg.pat[2];
      GPR_OFF_PAT_W3:   s_next.rsp.rdata = s_reg.pat[3];
      GPR_OFF_LEG_WR:   s_next.rsp.rdata = s_reg.leg_wr;
      GPR_OFF_LEG_RD:   s_next.rsp.rdata = s_reg.leg_rd;
      GPR_OFF_LINE_TRG: s_next.rsp.rdata = s_reg.line_trg;
      GPR_OFF_BLIT_TRG: s_next.rsp.rdata = s_reg.blit_trg;
      default: begin
        s_next.rsp.rdata = GPR_RESET_WORD;
        s_next.rsp.hit   = 1'b0;
      end
    endcase
    if (!req_in.rd) begin
      s_next.rsp.rdata = GPR_RESET_WORD;
      s_next.rsp.hit   = 1'b0;
    end
    if (req_in.wr) begin
      unique case (req_in.addr)
        GPR_OFF_DEST:    s_next.dest    = req_in.wdata;
        GPR_OFF_SIZE:    s_next.size    = req_in.wdata;
        GPR_OFF_SRC:     s_next.src     = req_in.wdata;
        GPR_OFF_SRC_COL: s_next.src_col = req_in.wdata;
        GPR_OFF_PAT_LO:  s_next.pat_lo  = req_in.wdata;
        GPR_OFF_PAT_HI:  s_next.pat_hi  = req_in.wdata;
        GPR_OFF_PAT_W0:  s_next.pat[0]  = req_in.wdata;
        GPR_OFF_PAT_W1:  s_next.pat[1]  = req_in.wdata;
        GPR_OFF_PAT_W2:  s_next.pat[2]  = req_in.wdata;
        GPR_OFF_PAT_W3:  s_next.pat[3]  = req_in.wdata;
        GPR_OFF_LEG_WR:  s_next.leg_wr  = req_in.wdata;
        GPR_OFF_LEG_RD:  s_next.leg_rd  = req_in.wdata;
        GPR_OFF_LINE_TRG: begin
          s_next.line_trg = req_in.wdata;
          s_next.op       = build_op(s_reg, 1'b1);
          s_next.start    = 1'b1;
          s_next.state    = GPR_LINE;
        end
        GPR_OFF_BLIT_TRG: begin
          s_next.blit_trg = req_in.wdata;
          s_next.op       = build_op(s_reg, 1'b0);
          s_next.start    = 1'b1;
          s_next.state    = GPR_BLIT;
        end
        default: begin
        end
      endcase
    end
    // Back to idle once the engine has taken the job and finished
    if (!s_next.start && !engine_busy_in && !s_reg.start) begin
      s_next.state = GPR_IDLE;
    end
    // Busy leaves from its own flop so the output is registered
    s_next.busy = (s_next.state != GPR_IDLE);
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      s_reg       <= '0;
      s_reg.state <= GPR_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign rsp_out              = s_reg.rsp;
  assign op_out               = s_reg.op;
  assign start_out            = s_reg.start;
  assign legacy_write_ctl_out = s_reg.leg_wr;
  assign legacy_read_ctl_out  = s_reg.leg_rd;
  assign busy_out             = s_reg.busy;

  // ==========================================================================
  // Checks
  AST_DEST_SPLIT: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    start_out |-> op_out.dest_y == $past(s_reg.dest[31:16]) &&
                  op_out.dest_x == $past(s_reg.dest[15:0]))
    else $error("Destination halves wrong");

  AST_BLIT_EMPTY: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_BLIT_TRG &&
     s_reg.size[15:0] == 16'h0000) |=> (start_out && op_out.empty))
    else $error("Zero height blit not marked empty");

  AST_LINE_LEN14: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (start_out && op_out.is_line) |-> op_out.width_or_len[15:14] == 2'b00)
    else $error("Line length exceeds 14 bits");

  AST_LINE_ERR: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_LINE_TRG) |=>
      op_out.height_or_err == $past(s_reg.size[15:0]))
    else $error("Initial error term not taken");

  AST_SRC_SPLIT: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_BLIT_TRG) |=>
      op_out.src_x_or_axial == $past(s_reg.src[31:16]) &&
      op_out.src_y_or_diag == $past(s_reg.src[15:0]))
    else $error("Source coordinate halves wrong");

  AST_PAT_ORDER: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_BLIT_TRG) |=>
      op_out.pattern[127:96] == $past(s_reg.pat[3]) &&
      op_out.pattern[31:0] == $past(s_reg.pat[0]))
    else $error("Pattern word order wrong");

  AST_READBACK: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_SRC_COL) ##1
    (req_in.rd && req_in.addr == GPR_OFF_SRC_COL && !req_in.wr) |=>
      rsp_out.rdata == $past(req_in.wdata, 2))
    else $error("Register readback differs");

  AST_START_PULSE: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_LINE_TRG) |=>
      start_out && op_out.is_line && busy_out)
    else $error("Line trigger did not start");

  AST_UNMAPPED: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.rd && req_in.addr == 16'h8118) |=>
      rsp_out.rvalid && !rsp_out.hit && rsp_out.rdata == 32'h0000_0000)
    else $error("Unmapped read not zero");

  AST_SRC_COLORS: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    start_out |->
      op_out.source_color_zero == $past(s_reg.src_col[31:16]) &&
      op_out.source_color_one == $past(s_reg.src_col[15:0]))
    else $error("Source colour halves wrong");

  AST_PAT_COLORS: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    start_out |->
      {op_out.pattern_color_zero, op_out.pattern_color_one,
       op_out.pattern_color_two, op_out.pattern_color_three} ==
      $past({s_reg.pat_lo, s_reg.pat_hi}))
    else $error("Pattern colours misplaced");

  AST_PAT_FULL: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    start_out |-> op_out.pattern ==
      $past({s_reg.pat[3], s_reg.pat[2], s_reg.pat[1], s_reg.pat[0]}))
    else $error("Pattern not formed from four words");

  AST_LINE_STEPS: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_LINE_TRG) |=>
      op_out.src_x_or_axial == $past(s_reg.src[31:16]) &&
      op_out.src_y_or_diag == $past(s_reg.src[15:0]))
    else $error("Line error steps wrong");

  AST_LINE_NOT_EMPTY: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (start_out && op_out.is_line) |-> !op_out.empty)
    else $error("Line marked empty");

  AST_BLIT_START: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_BLIT_TRG) |=>
      start_out && !op_out.is_line && busy_out &&
      op_out.width_or_len == $past(s_reg.size[31:16]))
    else $error("Blit trigger did not start");

  AST_START_CAUSE: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    start_out |-> $past(req_in.wr) &&
      ($past(req_in.addr) == GPR_OFF_LINE_TRG ||
       $past(req_in.addr) == GPR_OFF_BLIT_TRG))
    else $error("Start without trigger write");

  AST_LEGACY_HOLD: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (req_in.wr && req_in.addr == GPR_OFF_LEG_WR) |=>
      legacy_write_ctl_out == $past(req_in.wdata))
    else $error("Legacy write control not stored");

  // Checked without disable so that the reset cycles themselves count
  AST_RESET_ZERO: assert property (@(posedge clock_in)
    !resetn_in |=> rsp_out == '0 && !start_out && !busy_out &&
      op_out == '0 && legacy_read_ctl_out == 32'h0000_0000)
    else $error("Outputs not cleared by reset");

  COV_LINE: cover property (@(posedge clock_in) disable iff (!resetn_in)
    start_out && op_out.is_line);
  COV_BLIT: cover property (@(posedge clock_in) disable iff (!resetn_in)
    start_out && !op_out.is_line && !op_out.empty);
  COV_EMPTY: cover property (@(posedge clock_in) disable iff (!resetn_in)
    start_out && op_out.empty);
  COV_READBACK: cover property (@(posedge clock_in) disable iff (!resetn_in)
    rsp_out.rvalid && rsp_out.hit);

endmodule

// ### bench/gpr_host_model.sv
// Host software model issuing single-cycle register accesses
`timescale 1ns/1ps
module gpr_host_model
  import gpr_pkg::*;
(
  input  wire logic clock_in,
  output gpr_req_t  req_out
);
  initial req_out = '0;
  // ==========================================================================
  // Bus cycles, entered just after a rising edge
  task automatic access(input logic w, input logic r,
                        input logic [15:0] a, input logic [31:0] d);
    req_out <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clock_in);
  endtask
  // Released bus scrambles address and data so stale values mean nothing
  task automatic idle();
    req_out <= '{wr: 1'h0, rd: 1'h0, addr: ~req_out.addr,
                 wdata: ~req_out.wdata};
    @(posedge clock_in);
  endtask
  // ==========================================================================
  // Word formats that software must build
  function automatic logic [31:0] color8(input logic [7:0] c0,
                                         input logic [7:0] c1);
    return {c0, c0, c1, c1};
  endfunction
  function automatic logic [31:0] line_size(input logic [13:0] len,
                                            input logic [15:0] err);
    return {2'h0, len, err};
  endfunction
endmodule

// ### bench/tb.sv
// Self-checking testbench of the parameter register bank
`timescale 1ns/1ps
module tb
  import gpr_pkg::*;
();
  logic        clock_in, resetn_in, engine_busy_in, start, busy;
  gpr_req_t    req;
  gpr_rsp_t    rsp;
  gpr_op_t     op;
  logic [31:0] lw, lr;
  logic [31:0] sh [0:19];
  gpr_rsp_t    rq [$];
  gpr_op_t     oq [$];
  int          mismatches, n_compared;

  gpr_host_model gpr_host_model_i (.clock_in(clock_in), .req_out(req));
  gpr_param_regs gpr_param_regs_i (
    .clock_in(clock_in), .resetn_in(resetn_in), .req_in(req),
    .engine_busy_in(engine_busy_in), .rsp_out(rsp), .op_out(op),
    .start_out(start), .legacy_write_ctl_out(lw),
    .legacy_read_ctl_out(lr), .busy_out(busy));

  // ==========================================================================
  // Compare tasks and closing
  task automatic fail(string n, logic [383:0] e, logic [383:0] g);
    mismatches++;
    $display("Error %s expected %h seen %h", n, e, g);
  endtask
  task automatic chk_rsp(gpr_rsp_t e, gpr_rsp_t g);
    n_compared++;
    if (g !== e) fail("rsp_out", 384'(e), 384'(g));
  endtask
  task automatic chk_op(gpr_op_t e, gpr_op_t g);
    n_compared++;
    if (g !== e) fail("op_out", 384'(e), 384'(g));
  endtask
  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) fail(n, 384'(e), 384'(g));
  endtask
  task automatic end_sim();
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Drivers that note expectations
  function automatic logic is_reg(int i);
    return i inside {[0:5], [8:11], 16, 17};
  endfunction
  // Shadow slot of an offset; the two trigger words sit at 18 and 19
  function automatic int idx(logic [15:0] a);
    idx = -1;
    if (a[15:7] == 9'h102 && is_reg(a[6:2]))
      idx = int'(a[6:2]);
    if (a == GPR_OFF_LINE_TRG)
      idx = 18;
    if (a == GPR_OFF_BLIT_TRG)
      idx = 19;
  endfunction
  task automatic wr(logic [15:0] a, logic [31:0] d);
    if (idx(a) >= 0)
      sh[idx(a)] = d;
    gpr_host_model_i.access(1'h1, 1'h0, a, d);
  endtask
  task automatic rd(logic [15:0] a);
    logic m;
    m = idx(a) >= 0;
    rq.push_back('{rvalid: 1'h1, hit: m, rdata: m ? sh[idx(a)] : 32'h0});
    gpr_host_model_i.access(1'h0, 1'h1, a, 32'h0);
  endtask
  task automatic trig(logic ln);
    gpr_op_t o;
    o = '{ln, !ln && (sh[1][31:16] == 16'h0 || sh[1][15:0] == 16'h0),
          sh[0][31:16], sh[0][15:0],
          ln ? {2'h0, sh[1][29:16]} : sh[1][31:16], sh[1][15:0],
          sh[2][31:16], sh[2][15:0],
          sh[3][31:16], sh[3][15:0],
          sh[4][31:16], sh[4][15:0], sh[5][31:16], sh[5][15:0],
          {sh[11], sh[10], sh[9], sh[8]}};
    oq.push_back(o);
    wr(ln ? GPR_OFF_LINE_TRG : GPR_OFF_BLIT_TRG, $urandom);
  endtask

  // Watches the outputs and takes the oldest note for each result
  always @(negedge clock_in) begin
    if (rsp.rvalid === 1'h1)
      chk_rsp(rq.size() > 0 ? rq.pop_front() : '0, rsp);
    if (start === 1'h1)
      chk_op(oq.size() > 0 ? oq.pop_front() : '0, op);
  end

  initial begin
    clock_in = 1'h0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    resetn_in = 1'h0;
    engine_busy_in = 1'h0;
    mismatches = 0;
    n_compared = 0;
    foreach (sh[i]) sh[i] = 32'h0;
    void'($urandom(4959));
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'h1;
    @(posedge clock_in);
    // Reset contents and a trigger register
    for (int i = 0; i < 18; i++)
      if (is_reg(i))
        rd(16'h8100 + 16'(4 * i));
    rd(GPR_OFF_BLIT_TRG);
    // Random contents back to back, unmapped write ignored
    for (int i = 0; i < 18; i++)
      if (is_reg(i))
        wr(16'h8100 + 16'(4 * i), $urandom);
    wr(16'h8118, $urandom);
    for (int i = 0; i < 18; i++)
      if (is_reg(i))
        rd(16'h8100 + 16'(4 * i));
    rd(16'h8118);
    gpr_host_model_i.idle();
    chk_word("legacy_write_ctl", sh[16], lw);
    chk_word("legacy_read_ctl", sh[17], lr);
    // Blit while engine busy, then zero width, then zero height, back to back
    engine_busy_in <= 1'h1;
    trig(1'h0);
    gpr_host_model_i.idle();
    #1 chk_word("busy_out", 32'h1, {31'h0, busy});
    @(posedge clock_in);
    wr(GPR_OFF_SIZE, {16'h0, 16'($urandom)});
    trig(1'h0);
    wr(GPR_OFF_SIZE, {16'($urandom), 16'h0});
    trig(1'h0);
    // Vector with 8-bit colours and random steps
    wr(GPR_OFF_SRC_COL, gpr_host_model_i.color8(8'($urandom), 8'($urandom)));
    rd(GPR_OFF_SRC_COL);
    wr(GPR_OFF_SRC, $urandom);
    wr(GPR_OFF_SIZE,
       gpr_host_model_i.line_size(14'($urandom), 16'($urandom)));
    trig(1'h1);
    trig(1'h0);
    rd(GPR_OFF_LINE_TRG);
    rd(GPR_OFF_BLIT_TRG);
    engine_busy_in <= 1'h0;
    repeat (3) gpr_host_model_i.idle();
    #1 chk_word("busy_out", 32'h0, {31'h0, busy});
    chk_word("notes_left", 32'h0, rq.size() + oq.size());
    end_sim();
  end
endmodule
